// >>> tcp_pins.sv
// Top of the transceiver control and status pin logic.
// Assumes a host on AXI4-Lite and pin levels synchronous to aclk.
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
module tcp_pins
  import tcp_pkg::*;
(
  // Clock and reset
  input  wire logic      aclk,
  input  wire logic      aresetn,
  // AXI4-Lite write
  input  wire logic      awvalid,
  output logic           awready,
  input  wire tcp_pkg::tcp_addr_t awaddr,
  input  wire logic [2:0] awprot,
  input  wire logic      wvalid,
  output logic           wready,
  input  wire tcp_pkg::tcp_data_t wdata,
  input  wire logic [3:0] wstrb,
  output logic           bvalid,
  input  wire logic      bready,
  output tcp_pkg::tcp_resp_t bresp,
  // AXI4-Lite read
  input  wire logic      arvalid,
  output logic           arready,
  input  wire tcp_pkg::tcp_addr_t araddr,
  input  wire logic [2:0] arprot,
  output logic           rvalid,
  input  wire logic      rready,
  output tcp_pkg::tcp_data_t rdata,
  output tcp_pkg::tcp_resp_t rresp,
  // Transmit control pins
  input  wire logic      transmit_disable_in,
  output logic           tx_disable_out,
  input  wire logic [`TCP_FLT_N-1:0] internal_fault_in,
  input  wire logic      transmit_fault_i,
  output logic           transmit_fault_o,
  output logic           transmit_fault_oe,
  // Shutdown pin, doubling as external fault input
  input  wire logic      shutdown_i,
  output logic           shutdown_o,
  output logic           shutdown_oe,
  // Rate select
  input  wire logic      rate_select_in,
  output logic           rate_select_o,
  output logic           rate_select_oe,
  // Supply monitor pin
  output logic           supply_monitor_analog_en,
  output logic           supply_monitor_o,
  output logic           supply_monitor_oe,
  // Analog front end steering
  output logic           temp_remote_sel,
  output logic [`TCP_TAP_W-1:0] rx_trim_tap,
  output logic           tx_mon_range_quarter,
  output logic           fb_invert,
  output logic           fb_scale_sel,
  // Interrupt
  output logic           irq
);
  tcp_reg_if rg ();

  logic [4:0]  ctrl_q;
  logic [6:0]  oem_q;
  logic [`TCP_TAP_W-1:0] trim_q;
  tcp_ev_t     mask_q;
  logic        int_fault, ext_fault, fault_now, fault_prev_q;
  logic        transmit_disable_status_prev_q, rate_select_status_prev_q, soft_transmit_disable_status, soft_rate_select_status, int_pin_en;
  tcp_pin_mode_t mode;
  logic [4:0]  pin_stat;

  // ==========================================================================
  // Address decode
  // Shared by the write and the read path.
  function automatic logic tcp_hit(input tcp_addr_t a, input logic wr);
    unique case (a)
      `TCP_A_USER_CTRL, `TCP_A_OEM_CFG1, `TCP_A_RX_TRIM,
      `TCP_A_IRQ_STAT, `TCP_A_IRQ_MASK: tcp_hit = 1'b1;
      `TCP_A_PIN_STAT: tcp_hit = !wr;
      default:         tcp_hit = 1'b0;
    endcase
  endfunction : tcp_hit

  // ==========================================================================
  // Submodules
  tcp_axil u_axil (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awvalid (awvalid),
    .awready (awready),
    .awaddr  (awaddr),
    .wvalid  (wvalid),
    .wready  (wready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .bvalid  (bvalid),
    .bready  (bready),
    .bresp   (bresp),
    .arvalid (arvalid),
    .arready (arready),
    .araddr  (araddr),
    .rvalid  (rvalid),
    .rready  (rready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rg      (rg.slave)
  );

  tcp_irq u_irq (
    .aclk    (aclk),
    .aresetn (aresetn),
    .rg      (rg.irqs)
  );

  // ==========================================================================
  // Register writes
  // Status clears on reads and ignores writes; the pin status is read only.
  // A write with byte lane 0 off changes nothing; it is answered OKAY except at the pin status and unmapped offsets.
  assign rg.wr_ok = tcp_hit(rg.wr_addr, 1'b1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `TCP_R_USER_CTRL;
      oem_q  <= `TCP_R_OEM_CFG1;
      trim_q <= `TCP_R_RX_TRIM;
      mask_q <= `TCP_R_IRQ_MASK;
    end else if (rg.wr_en && rg.wr_lane0) begin
      unique case (rg.wr_addr)
        `TCP_A_USER_CTRL: ctrl_q <= rg.wr_data[4:0];
        `TCP_A_OEM_CFG1:  oem_q  <= rg.wr_data[6:0];
        `TCP_A_RX_TRIM:   trim_q <= rg.wr_data[`TCP_TAP_W-1:0];
        `TCP_A_IRQ_MASK:  mask_q <= rg.wr_data[`TCP_EV_N-1:0];
        default: ;
      endcase
    end
  end

  assign soft_transmit_disable_status = ctrl_q[`TCP_B_SOFT_TRANSMIT_DISABLE_STATUS];
  assign soft_rate_select_status  = ctrl_q[`TCP_B_SOFT_RATE_SELECT_STATUS];
  assign int_pin_en = ctrl_q[`TCP_B_INT_PIN_EN];
  assign mode       = oem_q[`TCP_B_EXT_FAULT] ? TCP_FAULT_IN : TCP_SHUTDOWN_OUT_OUT;
  assign rg.mask    = mask_q;

  // ==========================================================================
  // Register reads
  assign pin_stat[`TCP_B_ST_TRANSMIT_DISABLE_STATUS] = transmit_disable_in;
  assign pin_stat[`TCP_B_ST_TRANSMIT_FAULT_STATUS] = transmit_fault_i;
  assign pin_stat[`TCP_B_ST_RATE_SELECT_STATUS]  = rate_select_in;
  assign pin_stat[`TCP_B_ST_TXOFF] = tx_disable_out;
  assign pin_stat[`TCP_B_ST_SHUTDOWN_OUT]  = shutdown_oe && (shutdown_o == oem_q[`TCP_B_SHUTDOWN_OUT_POL]);

  assign rg.rd_ok  = tcp_hit(rg.rd_addr, 1'b0);
  assign rg.rd_clr = rg.rd_en && (rg.rd_addr == `TCP_A_IRQ_STAT);

  always_comb begin
    rg.rd_data = '0;
    unique case (rg.rd_addr)
      `TCP_A_USER_CTRL: rg.rd_data[4:0] = ctrl_q;
      `TCP_A_PIN_STAT:  rg.rd_data[4:0] = pin_stat;
      `TCP_A_OEM_CFG1:  rg.rd_data[6:0] = oem_q;
      `TCP_A_RX_TRIM:   rg.rd_data[`TCP_TAP_W-1:0] = trim_q;
      `TCP_A_IRQ_STAT:  rg.rd_data[`TCP_EV_N-1:0] = rg.status;
      `TCP_A_IRQ_MASK:  rg.rd_data[`TCP_EV_N-1:0] = mask_q;
      default: ;
    endcase
  end

  // ==========================================================================
  // Fault merge and transmit pins
  // Open-drain pins only ever drive low; a pull-up gives the high level.
  assign int_fault = |internal_fault_in;
  assign ext_fault = (mode == TCP_FAULT_IN) && shutdown_i;
  assign fault_now = int_fault || ext_fault;

  assign transmit_fault_o = 1'b0;
  assign rate_select_o    = 1'b0;
  assign supply_monitor_o = 1'b0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_disable_out    <= 1'b1;
      transmit_fault_oe <= 1'b1;
    end else begin
      tx_disable_out    <= transmit_disable_in || soft_transmit_disable_status;
      transmit_fault_oe <= !fault_now;
    end
  end

  // The shutdown pin is released one cycle after external-fault mode is chosen.
  // In that cycle the merge may see the device's own drive on the pin, so a mode
  // switch belongs in a quiet moment.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shutdown_oe <= 1'b0;
      shutdown_o  <= 1'b0;
    end else begin
      shutdown_oe <= (mode == TCP_SHUTDOWN_OUT_OUT);
      shutdown_o  <= int_fault ? oem_q[`TCP_B_SHUTDOWN_OUT_POL] : !oem_q[`TCP_B_SHUTDOWN_OUT_POL];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      rate_select_oe <= 1'b1;
    else
      rate_select_oe <= !(rate_select_in || soft_rate_select_status);
  end

  // ==========================================================================
  // Supply monitor pin and interrupt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      supply_monitor_analog_en <= 1'b1;
      supply_monitor_oe        <= 1'b0;
    end else begin
      supply_monitor_analog_en <= !int_pin_en;
      supply_monitor_oe        <= int_pin_en && rg.irq;
    end
  end

  assign irq = rg.irq;

  // Events: fault rising, and any change of the disable or rate select pin.
  // Previous levels reset to the idle pin level, so reset itself raises no event.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_prev_q <= 1'b0;
      transmit_disable_status_prev_q <= 1'b0;
      rate_select_status_prev_q  <= 1'b0;
    end else begin
      fault_prev_q <= fault_now;
      transmit_disable_status_prev_q <= transmit_disable_in;
      rate_select_status_prev_q  <= rate_select_in;
    end
  end

  assign rg.ev = {rate_select_in ^ rate_select_status_prev_q,
                  transmit_disable_in ^ transmit_disable_status_prev_q,
                  fault_now && !fault_prev_q};

  // ==========================================================================
  // Analog front end steering
  assign temp_remote_sel      = oem_q[`TCP_B_ZONE];
  assign tx_mon_range_quarter = oem_q[`TCP_B_MON_QUART];
  assign fb_invert            = oem_q[`TCP_B_FB_INV];
  assign fb_scale_sel         = oem_q[`TCP_B_FB_SCALE];
  assign rx_trim_tap          = trim_q;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  transmit_disable_status_pin_a: assert property (transmit_disable_in |=> tx_disable_out)
    else $error("disable pin did not disable transmitter");
  transmit_disable_status_soft_a: assert property (
    (aresetn && !transmit_disable_in && !soft_transmit_disable_status) |=> !tx_disable_out)
    else $error("transmitter disabled with no cause");
  transmit_disable_status_stat_a: assert property (pin_stat[`TCP_B_ST_TRANSMIT_DISABLE_STATUS] == transmit_disable_in)
    else $error("disable status does not mirror pin");
  fault_out_a: assert property (int_fault |=> !transmit_fault_oe)
    else $error("fault output not released on fault");
  ext_fault_a: assert property (
    (mode == TCP_FAULT_IN && shutdown_i && !int_fault) |=> !transmit_fault_oe)
    else $error("external fault not merged");
  shutdown_out_out_a: assert property ((mode == TCP_SHUTDOWN_OUT_OUT && int_fault) |=>
    (shutdown_oe && shutdown_o == $past(oem_q[`TCP_B_SHUTDOWN_OUT_POL])))
    else $error("shutdown not asserted at chosen polarity");
  vin_analog_a: assert property (!int_pin_en |=> (supply_monitor_analog_en && !supply_monitor_oe))
    else $error("supply pin driven in analog mode");
  rate_select_status_or_a: assert property ((rate_select_in || soft_rate_select_status) |=> !rate_select_oe)
    else $error("rate select output not released");
  rate_select_status_low_a: assert property ((!rate_select_in && !soft_rate_select_status) |=> rate_select_oe)
    else $error("rate select output not pulled low");
  rate_select_status_stat_a: assert property (pin_stat[`TCP_B_ST_RATE_SELECT_STATUS] == rate_select_in)
    else $error("rate select status does not mirror pin");
  int_pin_a: assert property ((int_pin_en && rg.irq) |=> supply_monitor_oe)
    else $error("interrupt pin not pulled low while pending");
  int_pin_off_a: assert property ((int_pin_en && !rg.irq) |=> !supply_monitor_oe)
    else $error("interrupt pin held low with nothing pending");
  ext_mode_in_a: assert property ((mode == TCP_FAULT_IN) |=> !shutdown_oe)
    else $error("shutdown pin driven in external fault mode");

  fault_seen_c: cover property (fault_now ##1 !transmit_fault_oe);
  ext_mode_c:   cover property (mode == TCP_FAULT_IN && shutdown_i);
  irq_pin_c:    cover property (int_pin_en && rg.irq ##1 supply_monitor_oe);
  stat_read_c:  cover property (rg.rd_clr && |rg.status);
  shutdown_out_pol_c:   cover property (mode == TCP_SHUTDOWN_OUT_OUT && int_fault ##1 shutdown_oe);
endmodule : tcp_pins

// >>> tcp_cfg.svh
// Offsets, field positions and reset values of the control and status pin block.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
`ifndef TCP_CFG_SVH
`define TCP_CFG_SVH

// ==========================================================================
// Register offsets
`define TCP_A_USER_CTRL  8'h00
`define TCP_A_PIN_STAT   8'h04
`define TCP_A_OEM_CFG1   8'h08
`define TCP_A_RX_TRIM    8'h0C
`define TCP_A_IRQ_STAT   8'h10
`define TCP_A_IRQ_MASK   8'h14

// ==========================================================================
// Field positions
`define TCP_B_SOFT_TRANSMIT_DISABLE_STATUS 0
`define TCP_B_SOFT_RATE_SELECT_STATUS  3
`define TCP_B_INT_PIN_EN 4
`define TCP_B_ST_TRANSMIT_DISABLE_STATUS   0
`define TCP_B_ST_TRANSMIT_FAULT_STATUS   1
`define TCP_B_ST_RATE_SELECT_STATUS    2
`define TCP_B_ST_TXOFF   3
`define TCP_B_ST_SHUTDOWN_OUT    4
`define TCP_B_ZONE       0
`define TCP_B_EXT_FAULT  1
`define TCP_B_SHUTDOWN_OUT_POL   2
`define TCP_B_MON_QUART  4
`define TCP_B_FB_INV     5
`define TCP_B_FB_SCALE   6
`define TCP_TAP_W        5
`define TCP_EV_N         3
`define TCP_FLT_N        4

// ==========================================================================
// Reset values and bus answers
`define TCP_R_USER_CTRL  5'h00
`define TCP_R_OEM_CFG1   7'h04
`define TCP_R_RX_TRIM    5'h00
`define TCP_R_IRQ_MASK   3'h0
`define TCP_RESP_OKAY    2'h0
`define TCP_RESP_SLVERR  2'h2

`endif

// >>> tcp_pkg.sv
// Types shared by the control and status pin block.
// Assumes tcp_cfg.svh is on the include path.
package tcp_pkg;
  `include "tcp_cfg.svh"

  typedef logic [7:0]  tcp_addr_t;
  typedef logic [31:0] tcp_data_t;
  typedef logic [1:0]  tcp_resp_t;
  typedef logic [`TCP_EV_N-1:0] tcp_ev_t;
  typedef enum logic {TCP_SHUTDOWN_OUT_OUT, TCP_FAULT_IN} tcp_pin_mode_t;
endpackage : tcp_pkg

// >>> tcp_reg_if.sv
// Internal carrier between the bus slave, the register file and the interrupt unit.
// Assumes all parties run on one clock.
`timescale 1ns/10ps
interface tcp_reg_if;
  import tcp_pkg::*;
  logic      wr_en;
  tcp_addr_t wr_addr;
  tcp_data_t wr_data;
  logic      wr_lane0;
  logic      wr_ok;
  logic      rd_en;
  tcp_addr_t rd_addr;
  tcp_data_t rd_data;
  logic      rd_ok;
  tcp_ev_t   ev;
  tcp_ev_t   mask;
  tcp_ev_t   status;
  logic      rd_clr;
  logic      irq;

  modport slave (output wr_en, wr_addr, wr_data, wr_lane0, rd_en, rd_addr,
                 input wr_ok, rd_data, rd_ok);
  modport regs  (input wr_en, wr_addr, wr_data, wr_lane0, rd_en, rd_addr, status, irq,
                 output wr_ok, rd_data, rd_ok, ev, mask, rd_clr);
  modport irqs  (input ev, mask, rd_clr, output status, irq);
endinterface : tcp_reg_if

// >>> tcp_axil.sv
// AXI4-Lite slave: one write and one read under way at a time.
// Assumes the register side decodes the address in the same cycle.
`timescale 1ns/10ps
module tcp_axil
  import tcp_pkg::*;
(
  // Clock and reset
  input  wire logic      aclk,
  input  wire logic      aresetn,
  // Write channels
  input  wire logic      awvalid,
  output logic           awready,
  input  wire tcp_addr_t awaddr,
  input  wire logic      wvalid,
  output logic           wready,
  input  wire tcp_data_t wdata,
  input  wire logic [3:0] wstrb,
  output logic           bvalid,
  input  wire logic      bready,
  output tcp_resp_t      bresp,
  // Read channels
  input  wire logic      arvalid,
  output logic           arready,
  input  wire tcp_addr_t araddr,
  output logic           rvalid,
  input  wire logic      rready,
  output tcp_data_t      rdata,
  output tcp_resp_t      rresp,
  // Register side
  tcp_reg_if.slave       rg
);
  logic      aw_held_q, w_held_q, wr_go;
  tcp_addr_t awaddr_q;
  tcp_data_t wdata_q;
  logic      lane0_q;

  // ==========================================================================
  // Write path
  // Address and data are caught independently, so either may come first.
  assign awready = !aw_held_q && !bvalid;
  assign wready  = !w_held_q && !bvalid;
  assign wr_go   = aw_held_q && w_held_q && !bvalid;
  assign rg.wr_en    = wr_go;
  assign rg.wr_addr  = awaddr_q;
  assign rg.wr_data  = wdata_q;
  assign rg.wr_lane0 = lane0_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q  <= '0;
    end else if (awvalid && awready) begin
      aw_held_q <= 1'b1;
      awaddr_q  <= awaddr;
    end else if (wr_go) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q  <= '0;
      lane0_q  <= 1'b0;
    end else if (wvalid && wready) begin
      w_held_q <= 1'b1;
      wdata_q  <= wdata;
      lane0_q  <= wstrb[0];
    end else if (wr_go) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= `TCP_RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp  <= rg.wr_ok ? `TCP_RESP_OKAY : `TCP_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ==========================================================================
  // Read path
  assign arready    = !rvalid;
  assign rg.rd_en   = arvalid && arready;
  assign rg.rd_addr = araddr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= `TCP_RESP_OKAY;
    end else if (rg.rd_en) begin
      rvalid <= 1'b1;
      rdata  <= rg.rd_data;
      rresp  <= rg.rd_ok ? `TCP_RESP_OKAY : `TCP_RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule : tcp_axil

// >>> tcp_irq.sv
// Sticky event status with mask and one level interrupt.
// Assumes rd_clr pulses when software reads the status register.
`timescale 1ns/10ps
module tcp_irq
  import tcp_pkg::*;
(
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Register side
  tcp_reg_if.irqs   rg
);
  tcp_ev_t st_q;

  // ==========================================================================
  // Sticky bits
  // A new event beats the read clear so it is never lost.
  genvar i;
  generate
    for (i = 0; i < `TCP_EV_N; i++) begin : g_bit
      always_ff @(posedge aclk) begin
        if (!aresetn)
          st_q[i] <= 1'b0;
        else if (rg.ev[i])
          st_q[i] <= 1'b1;
        else if (rg.rd_clr)
          st_q[i] <= 1'b0;
      end
    end
  endgenerate

  assign rg.status = st_q;
  assign rg.irq    = |(st_q & rg.mask);

  // ==========================================================================
  // Checks
  set_wins_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (rg.ev[0] && rg.rd_clr) |=> st_q[0])
    else $error("event lost against status clear");
endmodule : tcp_irq

// >>> tcp_host_model.sv
// Host-side model of the transceiver edge: disable, rate select and external fault drivers.
// Assumes one clock shared with the device; open-drain wires carry pull-ups on the host.
`timescale 1ns/10ps
module tcp_host_model (
  // Clock
  input  wire logic aclk,
  // Requests from the bench
  input  wire logic dis_req,
  input  wire logic rs_req,
  input  wire logic xflt_req,
  // Device pin drivers
  input  wire logic transmit_fault_oe,
  input  wire logic rate_select_oe,
  input  wire logic supply_monitor_oe,
  input  wire logic shutdown_o,
  input  wire logic shutdown_oe,
  // Wire levels
  output logic      transmit_disable_in,
  output logic      rate_select_in,
  output logic      transmit_fault_i,
  output logic      shutdown_i,
  output logic      rate_wire,
  output logic      int_wire
);
  initial begin
    transmit_disable_in = 1'b0;
    rate_select_in      = 1'b0;
  end
  // The host changes its pins just after an edge, like any clocked driver.
  always @(posedge aclk) begin
    transmit_disable_in <= dis_req;
    rate_select_in      <= rs_req;
  end
  // A released open-drain wire is pulled high, never left at its last value.
  assign transmit_fault_i = !transmit_fault_oe;
  assign rate_wire        = !rate_select_oe;
  assign int_wire         = !supply_monitor_oe;
  // The external fault source only reaches the pin while the device leaves it alone.
  assign shutdown_i = shutdown_oe ? shutdown_o : xflt_req;
endmodule : tcp_host_model

// >>> tcp_pins_tb.sv
// Self-checking bench for the transceiver control and status pin block.
// Assumes the host model on the pin side; this module is the AXI4-Lite master.
`timescale 1ns/10ps
module tcp_pins_tb;
  import tcp_pkg::*;
  // ====================
  // Signals
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, tx_disable_out, irq;
  logic        transmit_fault_o, transmit_fault_oe, shutdown_o, shutdown_oe;
  logic        rate_select_o, rate_select_oe, supply_monitor_o, supply_monitor_oe;
  logic        supply_monitor_analog_en, temp_remote_sel, tx_mon_range_quarter;
  logic        fb_invert, fb_scale_sel, transmit_disable_in, rate_select_in;
  logic        transmit_fault_i, shutdown_i, dis_req, rs_req, xflt_req, rate_wire, int_wire;
  logic [3:0]  wstrb, internal_fault_in;
  logic [2:0]  awprot, arprot;
  logic [4:0]  rx_trim_tap;
  tcp_addr_t   awaddr, araddr;
  tcp_data_t   wdata, rdata;
  tcp_resp_t   bresp, rresp;
  int          err_total, comparisons;
  logic [31:0] seed, v;
  logic [65:0] rx_exp;
  tcp_resp_t   bq[$];
  logic [65:0] rq[$];

  tcp_pins dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot, .wvalid, .wready,
    .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot, .rvalid,
    .rready, .rdata, .rresp, .transmit_disable_in, .tx_disable_out, .internal_fault_in,
    .transmit_fault_i, .transmit_fault_o, .transmit_fault_oe, .shutdown_i, .shutdown_o,
    .shutdown_oe, .rate_select_in, .rate_select_o, .rate_select_oe, .supply_monitor_analog_en,
    .supply_monitor_o, .supply_monitor_oe, .temp_remote_sel, .rx_trim_tap,
    .tx_mon_range_quarter, .fb_invert, .fb_scale_sel, .irq);
  tcp_host_model host (.aclk, .dis_req, .rs_req, .xflt_req, .transmit_fault_oe,
    .rate_select_oe, .supply_monitor_oe, .shutdown_o, .shutdown_oe, .transmit_disable_in,
    .rate_select_in, .transmit_fault_i, .shutdown_i, .rate_wire, .int_wire);

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // ====================
  // Helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic test_done();
    if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic settle();
    repeat (4) @(posedge aclk);
  endtask : settle

  // Ready is combinational and settled by the falling edge, so it is judged there
  // and acted on at the next rising edge.
  task automatic wr(input tcp_addr_t a, input tcp_data_t d, input tcp_resp_t r);
    logic pa, pw, pb, ta, tw, tb;
    @(posedge aclk);
    bq.push_back(r);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    {pa, pw, pb} = 3'h7;
    while (pb) begin
      @(negedge aclk);
      ta = pa && awready;
      tw = pw && wready;
      tb = bvalid;
      @(posedge aclk);
      if (ta) begin
        awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (tw) begin
        wvalid <= 1'b0;
        pw = 1'b0;
      end
      if (tb) begin
        bready <= 1'b0;
        pb = 1'b0;
      end
    end
  endtask : wr

  task automatic rd(input tcp_addr_t a, input tcp_data_t d, input tcp_data_t m,
                    input tcp_resp_t r);
    logic pa, pr, ta, tr;
    @(posedge aclk);
    rq.push_back({r, m, d & m});
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    {pa, pr} = 2'h3;
    while (pr) begin
      @(negedge aclk);
      ta = pa && arready;
      tr = rvalid;
      @(posedge aclk);
      if (ta) begin
        arvalid <= 1'b0;
        pa = 1'b0;
      end
      if (tr) begin
        rready <= 1'b0;
        pr = 1'b0;
      end
    end
  endtask : rd

  // ====================
  // Result monitor
  always @(posedge aclk) begin
    if (bvalid && bready) chk({32'h0, bresp}, {32'h0, bq.pop_front()});
    if (rvalid && rready) begin
      rx_exp = rq.pop_front();
      chk({rresp, rdata & rx_exp[63:32]}, {rx_exp[65:64], rx_exp[31:0]});
    end
  end

  initial begin
    repeat (5000) @(posedge aclk);
    err_total++;
    test_done();
  end

  // ====================
  // Scenarios
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, dis_req, rs_req, xflt_req} = '0;
    {awaddr, araddr, wdata} = '0;
    {awprot, arprot, internal_fault_in} = '0;
    wstrb = 4'hF;
    {err_total, comparisons} = '0;
    seed = 32'h57;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`TCP_A_USER_CTRL, 32'h0, 32'hFFFFFFFF, `TCP_RESP_OKAY);
    rd(`TCP_A_OEM_CFG1, 32'h4, 32'hFFFFFFFF, `TCP_RESP_OKAY);
    rd(8'h18, 32'h0, 32'hFFFFFFFF, `TCP_RESP_SLVERR);
    wr(`TCP_A_PIN_STAT, 32'h1F, `TCP_RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      wr(`TCP_A_USER_CTRL, {31'h0, i[1]}, `TCP_RESP_OKAY);
      dis_req <= i[0];
      settle();
      chk({33'h0, tx_disable_out}, {33'h0, i[0] | i[1]});
      rd(`TCP_A_PIN_STAT, {28'h0, i[0] | i[1], 2'h0, i[0]}, 32'hF, `TCP_RESP_OKAY);
    end
    dis_req <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      wr(`TCP_A_USER_CTRL, {28'h0, i[1], 3'h0}, `TCP_RESP_OKAY);
      rs_req <= i[0];
      settle();
      chk({32'h0, rate_wire, rate_select_o}, {32'h0, i[0] | i[1], 1'b0});
      rd(`TCP_A_PIN_STAT, {29'h0, i[0], 2'h0}, 32'h4, `TCP_RESP_OKAY);
    end
    for (int p = 0; p < 2; p++) begin
      wr(`TCP_A_OEM_CFG1, {29'h0, p[0], 2'h0}, `TCP_RESP_OKAY);
      internal_fault_in <= 4'h1 << p;
      settle();
      chk({31'h0, transmit_fault_i, shutdown_oe, shutdown_o}, {31'h0, 2'h3, p[0]});
      rd(`TCP_A_PIN_STAT, 32'h12, 32'h12, `TCP_RESP_OKAY);
      internal_fault_in <= 4'h0;
      settle();
      chk({32'h0, transmit_fault_i, shutdown_o}, {32'h0, 1'b0, !p[0]});
    end
    wr(`TCP_A_OEM_CFG1, 32'h2, `TCP_RESP_OKAY);
    xflt_req <= 1'b1;
    settle();
    chk({32'h0, shutdown_oe, transmit_fault_i}, 34'h1);
    xflt_req <= 1'b0;
    settle();
    chk({33'h0, transmit_fault_i}, 34'h0);
    wr(`TCP_A_USER_CTRL, 32'h10, `TCP_RESP_OKAY);
    rd(`TCP_A_IRQ_STAT, 32'h7, 32'h7, `TCP_RESP_OKAY);
    settle();
    chk({29'h0, transmit_fault_o, supply_monitor_o, supply_monitor_analog_en, int_wire, irq},
        34'h2);
    wr(`TCP_A_IRQ_MASK, 32'h1, `TCP_RESP_OKAY);
    rs_req <= 1'b0;
    settle();
    chk({32'h0, irq, int_wire}, 34'h1);
    wr(`TCP_A_IRQ_MASK, 32'h4, `TCP_RESP_OKAY);
    settle();
    chk({32'h0, irq, int_wire}, 34'h2);
    rd(`TCP_A_IRQ_STAT, 32'h4, 32'h4, `TCP_RESP_OKAY);
    settle();
    chk({32'h0, irq, int_wire}, 34'h1);
    wr(`TCP_A_USER_CTRL, 32'h0, `TCP_RESP_OKAY);
    settle();
    chk({33'h0, supply_monitor_analog_en}, 34'h1);
    repeat (4) begin
      v = xs();
      wr(`TCP_A_OEM_CFG1, (v & 32'h71) | 32'h4, `TCP_RESP_OKAY);
      wr(`TCP_A_RX_TRIM, {27'h0, v[12:8]}, `TCP_RESP_OKAY);
      settle();
      chk({30'h0, temp_remote_sel, tx_mon_range_quarter, fb_invert, fb_scale_sel},
          {30'h0, v[0], v[4], v[5], v[6]});
      chk({29'h0, rx_trim_tap}, {29'h0, v[12:8]});
      rd(`TCP_A_RX_TRIM, {27'h0, v[12:8]}, 32'h1F, `TCP_RESP_OKAY);
    end
    test_done();
  end
endmodule : tcp_pins_tb
